// [hdl/lkp_pkg.sv]
package lkp_pkg;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam int ADDR_W = 4;
	localparam logic [ADDR_W-1:0] OFF_CMD_STATUS = 4'h0;
	localparam logic [ADDR_W-1:0] OFF_CTRL = 4'h4;
	localparam logic [ADDR_W-1:0] OFF_STATE = 4'h8;
	localparam logic [15:0] CMD_STATUS_RESET = 16'h0000;
	localparam logic CTRL_RESET = 1'h0;

	// ----------------------------------------------------------------
	// Command/status field layout
	// ----------------------------------------------------------------
	localparam int BIT_CMD_ERROR = 15;
	localparam int BIT_CMD_VALID = 14;
	localparam int BIT_CMD_PARAM = 13;
	localparam int CMD_CODE_HI = 12;
	localparam int CMD_CODE_LO = 8;
	localparam int BIT_NOTIFY_LOST = 7;
	localparam int BIT_NOTIFY_VALID = 6;
	localparam int NOTIFY_CODE_HI = 5;
	localparam int BIT_ACCEPT_ALL = 0;

	// ----------------------------------------------------------------
	// Command codes
	// ----------------------------------------------------------------
	localparam logic [4:0] CMD_STOP = 5'h00;
	localparam logic [4:0] CMD_START = 5'h01;
	localparam logic [4:0] CMD_INIT = 5'h02;
	localparam logic [4:0] CMD_TRANS = 5'h03;
	localparam logic [4:0] CMD_STATUS = 5'h04;
	localparam logic [4:0] CMD_SELFTEST = 5'h05;
	localparam logic [4:0] CMD_CONNECT = 5'h07;
	localparam logic [4:0] CMD_SIM = 5'h08;
	localparam logic [4:0] CMD_RESET = 5'h09;
	localparam logic [4:0] CMD_RIM = 5'h0a;
	localparam logic [4:0] CMD_XID = 5'h0b;
	localparam logic [4:0] CMD_CFGR = 5'h0c;
	localparam logic [4:0] CMD_TEST = 5'h0d;
	localparam logic [4:0] CMD_DISC = 5'h0e;
	localparam logic [4:0] CMD_RD = 5'h0f;

	// ----------------------------------------------------------------
	// Notification codes and pending indications
	// ----------------------------------------------------------------
	localparam logic [5:0] NTF_IM = 6'h00;
	localparam logic [5:0] NTF_CONNECT = 6'h06;
	localparam logic [5:0] NTF_RESET = 6'h08;
	localparam logic [5:0] NTF_XID = 6'h0a;
	localparam logic [5:0] NTF_TEST = 6'h0c;
	localparam logic [5:0] NTF_CFGR = 6'h0d;
	localparam logic [5:0] NTF_DISC = 6'h0e;
	localparam int IND_IM = 0;
	localparam int IND_CONNECT = 1;
	localparam int IND_RESET = 2;
	localparam int IND_XID = 3;
	localparam int IND_CFGR = 4;
	localparam int IND_TEST = 5;
	localparam int IND_W = 6;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {PH_STOPPED, PH_DISCONNECTED, PH_INFO, PH_TRANSPARENT} lkp_phase_e;
	typedef enum logic [2:0] {FR_NONE, FR_UA, FR_RIM, FR_XID, FR_CFGR, FR_TEST, FR_DM, FR_RD}
		lkp_frame_e;

	typedef struct packed {
		logic ring_reset;
		logic init_fetch;
		logic status_write;
		logic self_test;
		logic t1_start;
		logic t1_stop;
		logic link_accept;
		logic unacked_resend;
		logic unacked_discard;
		logic frame_send;
		lkp_frame_e frame_kind;
		logic frame_final;
	} lkp_action_s;

	typedef struct packed {
		logic tx_all_ones;
		logic tx_flags;
		logic rx_ignore;
		logic dma_enable;
		logic no_header;
		logic accept_all;
		logic t1_running;
	} lkp_line_s;

endpackage : lkp_pkg

// [hdl/lkp_axil_slave.sv]
`timescale 1ns/1ps
`default_nettype none
module lkp_axil_slave #(
	parameter int AW = lkp_pkg::ADDR_W
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic [AW-1:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [AW-1:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	output logic wr_req,
	output logic [AW-1:0] wr_addr,
	output logic [31:0] wr_data,
	output logic [3:0] wr_strb,
	input wire logic wr_err,
	output logic [AW-1:0] rd_addr,
	input wire logic [31:0] rd_data,
	input wire logic rd_err
);
	logic aw_held;
	logic w_held;
	logic ar_held;

	// Address and data may arrive in either order; the write lands once both are held
	assign wr_req = aw_held && w_held && !bvalid;

	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			awready <= 1'b0;
			aw_held <= 1'b0;
			wr_addr <= '0;
		end
		else if (awvalid && awready)
		begin
			awready <= 1'b0;
			aw_held <= 1'b1;
			wr_addr <= awaddr;
		end
		else if (wr_req)
			aw_held <= 1'b0;
		else if (!aw_held && !bvalid)
			awready <= 1'b1;
	end

	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			wready <= 1'b0;
			w_held <= 1'b0;
			wr_data <= '0;
			wr_strb <= '0;
		end
		else if (wvalid && wready)
		begin
			wready <= 1'b0;
			w_held <= 1'b1;
			wr_data <= wdata;
			wr_strb <= wstrb;
		end
		else if (wr_req)
			w_held <= 1'b0;
		else if (!w_held && !bvalid)
			wready <= 1'b1;
	end

	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			bvalid <= 1'b0;
			bresp <= lkp_pkg::RESP_OKAY;
		end
		else if (wr_req)
		begin
			bvalid <= 1'b1;
			bresp <= wr_err ? lkp_pkg::RESP_SLVERR : lkp_pkg::RESP_OKAY;
		end
		else if (bready)
			bvalid <= 1'b0;
	end

	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			arready <= 1'b0;
			ar_held <= 1'b0;
			rd_addr <= '0;
			rvalid <= 1'b0;
			rdata <= '0;
			rresp <= lkp_pkg::RESP_OKAY;
		end
		else
		begin
			if (arvalid && arready)
			begin
				arready <= 1'b0;
				ar_held <= 1'b1;
				rd_addr <= araddr;
			end
			else if (ar_held)
			begin
				ar_held <= 1'b0;
				rvalid <= 1'b1;
				rdata <= rd_err ? 32'h00000000 : rd_data;
				rresp <= rd_err ? lkp_pkg::RESP_SLVERR : lkp_pkg::RESP_OKAY;
			end
			else if (rvalid && rready)
				rvalid <= 1'b0;
			else if (!rvalid)
				arready <= 1'b1;
		end
	end
endmodule : lkp_axil_slave
`default_nettype wire

// [hdl/lkp_cmd_port.sv]
// Overview of operation
// - Conflicting command sets error bit 15; write 1 clears, reset clears.
// - Host sets valid bit 14 with a command; device clears it after processing.
// - Connect/reset parameter 0 resends unacknowledged frames, 1 discards and frees them.
// - Stop enters stopped phase, halts DMA, sends ones, ignores receive data.
// - Start enters disconnected with ring reset and flags, or information transfer.
// - Start is accepted only in stopped or transparent phase.
// - Init fetches the initialization block, valid only while stopped.
// - Transparent phase passes frames bare; accept-all skips address filtering.
// - Transparent left by stop, reset, or start to information or disconnected.
// - Status request writes status buffer, any phase, only after init.
// - Self test runs only in the stopped phase.
// - Connect response only when disconnected and after a connect indication.
// - Code 8 answers SIM with UA after IM indication; transparent starts T1.
// - Code 9 answers SNRM with UA after reset indication; transparent stops T1.
// - Code 10 sends RIM at next poll with final bit from parameter.
// - Codes 11-13 send XID, CFGR, TEST after the matching indication.
// - Code 14 sends DM then enters the disconnected phase.
// - Code 15 sends RD with final bit from parameter.
// - Notification sets valid bit 6; host clears by writing 1; reset clears.
// - Notification while valid is set raises lost bit 7; clears with valid.
//
// The implementer's own choices: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module lkp_cmd_port (
	input wire logic CORE_CLK,
	input wire logic RSTN,
	input wire logic [lkp_pkg::ADDR_W-1:0] S_AXI_AWADDR,
	input wire logic S_AXI_AWVALID,
	output logic S_AXI_AWREADY,
	input wire logic [31:0] S_AXI_WDATA,
	input wire logic [3:0] S_AXI_WSTRB,
	input wire logic S_AXI_WVALID,
	output logic S_AXI_WREADY,
	output logic [1:0] S_AXI_BRESP,
	output logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	input wire logic [lkp_pkg::ADDR_W-1:0] S_AXI_ARADDR,
	input wire logic S_AXI_ARVALID,
	output logic S_AXI_ARREADY,
	output logic [31:0] S_AXI_RDATA,
	output logic [1:0] S_AXI_RRESP,
	output logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY,
	input wire logic NOTIFY_REQ,
	input wire logic [5:0] NOTIFY_CODE,
	output var lkp_pkg::lkp_phase_e PHASE,
	output var lkp_pkg::lkp_line_s LINE,
	output var lkp_pkg::lkp_action_s ACTION
);

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic [lkp_pkg::IND_W-1:0] ind_of_notify(input logic [5:0] code);
		logic [lkp_pkg::IND_W-1:0] r;
		r = '0;
		unique case (code)
			lkp_pkg::NTF_IM: r[lkp_pkg::IND_IM] = 1'b1;
			lkp_pkg::NTF_CONNECT: r[lkp_pkg::IND_CONNECT] = 1'b1;
			lkp_pkg::NTF_RESET: r[lkp_pkg::IND_RESET] = 1'b1;
			lkp_pkg::NTF_XID: r[lkp_pkg::IND_XID] = 1'b1;
			lkp_pkg::NTF_CFGR: r[lkp_pkg::IND_CFGR] = 1'b1;
			lkp_pkg::NTF_TEST: r[lkp_pkg::IND_TEST] = 1'b1;
			default: r = '0;
		endcase
		return r;
	endfunction : ind_of_notify

	function automatic logic [lkp_pkg::IND_W-1:0] ind_of_cmd(input logic [4:0] code);
		logic [lkp_pkg::IND_W-1:0] r;
		r = '0;
		unique case (code)
			lkp_pkg::CMD_SIM: r[lkp_pkg::IND_IM] = 1'b1;
			lkp_pkg::CMD_CONNECT: r[lkp_pkg::IND_CONNECT] = 1'b1;
			lkp_pkg::CMD_RESET: r[lkp_pkg::IND_RESET] = 1'b1;
			lkp_pkg::CMD_XID: r[lkp_pkg::IND_XID] = 1'b1;
			lkp_pkg::CMD_CFGR: r[lkp_pkg::IND_CFGR] = 1'b1;
			lkp_pkg::CMD_TEST: r[lkp_pkg::IND_TEST] = 1'b1;
			default: r = '0;
		endcase
		return r;
	endfunction : ind_of_cmd

	// ----------------------------------------------------------------
	// Bus slave
	// ----------------------------------------------------------------
	logic wr_req;
	logic [lkp_pkg::ADDR_W-1:0] wr_addr;
	logic [31:0] wr_data;
	logic [3:0] wr_strb;
	logic wr_err;
	logic [lkp_pkg::ADDR_W-1:0] rd_addr;
	logic [31:0] rd_data;
	logic rd_err;

	lkp_axil_slave #(
		.AW(lkp_pkg::ADDR_W)
	) u_slave (
		.clk(CORE_CLK),
		.rstn(RSTN),
		.awaddr(S_AXI_AWADDR),
		.awvalid(S_AXI_AWVALID),
		.awready(S_AXI_AWREADY),
		.wdata(S_AXI_WDATA),
		.wstrb(S_AXI_WSTRB),
		.wvalid(S_AXI_WVALID),
		.wready(S_AXI_WREADY),
		.bresp(S_AXI_BRESP),
		.bvalid(S_AXI_BVALID),
		.bready(S_AXI_BREADY),
		.araddr(S_AXI_ARADDR),
		.arvalid(S_AXI_ARVALID),
		.arready(S_AXI_ARREADY),
		.rdata(S_AXI_RDATA),
		.rresp(S_AXI_RRESP),
		.rvalid(S_AXI_RVALID),
		.rready(S_AXI_RREADY),
		.wr_req(wr_req),
		.wr_addr(wr_addr),
		.wr_data(wr_data),
		.wr_strb(wr_strb),
		.wr_err(wr_err),
		.rd_addr(rd_addr),
		.rd_data(rd_data),
		.rd_err(rd_err)
	);

	// ----------------------------------------------------------------
	// Register state
	// ----------------------------------------------------------------
	logic cmd_error_flag;
	logic cmd_valid_flag;
	logic cmd_param_bit;
	logic [4:0] cmd_code;
	logic notify_lost_flag;
	logic notify_valid_flag;
	logic [5:0] notify_code;
	logic accept_all_frames;
	logic init_done;
	logic t1_running;
	logic [lkp_pkg::IND_W-1:0] ind_pending;
	lkp_pkg::lkp_phase_e phase;
	lkp_pkg::lkp_phase_e next_phase;
	lkp_pkg::lkp_action_s next_action;

	logic wr_cmd_hi;
	logic wr_cmd_lo;
	logic wr_ctrl;
	logic cmd_ok;
	logic cmd_exec;
	logic notify_clear;
	logic notify_post;
	logic in_stopped;
	logic in_trans;

	assign wr_cmd_hi = wr_req && wr_addr == lkp_pkg::OFF_CMD_STATUS && wr_strb[1];
	assign wr_cmd_lo = wr_req && wr_addr == lkp_pkg::OFF_CMD_STATUS && wr_strb[0];
	assign wr_ctrl = wr_req && wr_addr == lkp_pkg::OFF_CTRL && wr_strb[0];
	assign wr_err = !(wr_addr == lkp_pkg::OFF_CMD_STATUS || wr_addr == lkp_pkg::OFF_CTRL
		|| wr_addr == lkp_pkg::OFF_STATE);
	assign in_stopped = phase == lkp_pkg::PH_STOPPED;
	assign in_trans = phase == lkp_pkg::PH_TRANSPARENT;

	// ----------------------------------------------------------------
	// Command check
	// ----------------------------------------------------------------
	// A command is judged against the phase at the cycle it is taken
	always_comb
	begin
		unique case (cmd_code)
			lkp_pkg::CMD_STOP: cmd_ok = 1'b1;
			lkp_pkg::CMD_START: cmd_ok = in_stopped || in_trans;
			lkp_pkg::CMD_INIT: cmd_ok = in_stopped;
			lkp_pkg::CMD_TRANS: cmd_ok = 1'b1;
			lkp_pkg::CMD_STATUS: cmd_ok = init_done;
			lkp_pkg::CMD_SELFTEST: cmd_ok = in_stopped;
			lkp_pkg::CMD_CONNECT:
				cmd_ok = phase == lkp_pkg::PH_DISCONNECTED
					&& ind_pending[lkp_pkg::IND_CONNECT];
			lkp_pkg::CMD_SIM, lkp_pkg::CMD_RESET:
				cmd_ok = in_trans
					|| (!in_stopped && |(ind_pending & ind_of_cmd(cmd_code)));
			lkp_pkg::CMD_XID, lkp_pkg::CMD_CFGR, lkp_pkg::CMD_TEST:
				cmd_ok = !in_stopped && !in_trans
					&& |(ind_pending & ind_of_cmd(cmd_code));
			lkp_pkg::CMD_RIM, lkp_pkg::CMD_DISC, lkp_pkg::CMD_RD:
				cmd_ok = !in_stopped && !in_trans;
			default: cmd_ok = 1'b0;
		endcase
	end

	assign cmd_exec = cmd_valid_flag && cmd_ok;

	// ----------------------------------------------------------------
	// Phase and actions
	// ----------------------------------------------------------------
	always_comb
	begin
		next_phase = phase;
		next_action = '0;
		next_action.frame_final = cmd_param_bit;
		if (cmd_exec)
		begin
			unique case (cmd_code)
				lkp_pkg::CMD_STOP: next_phase = lkp_pkg::PH_STOPPED;
				lkp_pkg::CMD_START:
				begin
					next_phase = cmd_param_bit ? lkp_pkg::PH_INFO : lkp_pkg::PH_DISCONNECTED;
					next_action.ring_reset = !cmd_param_bit;
				end
				lkp_pkg::CMD_INIT: next_action.init_fetch = 1'b1;
				lkp_pkg::CMD_TRANS: next_phase = lkp_pkg::PH_TRANSPARENT;
				lkp_pkg::CMD_STATUS: next_action.status_write = 1'b1;
				lkp_pkg::CMD_SELFTEST: next_action.self_test = 1'b1;
				lkp_pkg::CMD_CONNECT:
				begin
					next_phase = lkp_pkg::PH_INFO;
					next_action.link_accept = 1'b1;
					next_action.unacked_resend = !cmd_param_bit;
					next_action.unacked_discard = cmd_param_bit;
				end
				lkp_pkg::CMD_SIM:
				begin
					next_action.t1_start = in_trans;
					next_action.frame_send = !in_trans;
					next_action.frame_kind = lkp_pkg::FR_UA;
					next_action.frame_final = 1'b1;
				end
				lkp_pkg::CMD_RESET:
				begin
					next_action.t1_stop = in_trans;
					next_action.frame_send = !in_trans;
					next_action.frame_kind = lkp_pkg::FR_UA;
					next_action.frame_final = 1'b1;
					next_action.unacked_resend = !in_trans && !cmd_param_bit;
					next_action.unacked_discard = !in_trans && cmd_param_bit;
				end
				lkp_pkg::CMD_RIM:
				begin
					next_action.frame_send = 1'b1;
					next_action.frame_kind = lkp_pkg::FR_RIM;
				end
				lkp_pkg::CMD_XID:
				begin
					next_action.frame_send = 1'b1;
					next_action.frame_kind = lkp_pkg::FR_XID;
				end
				lkp_pkg::CMD_CFGR:
				begin
					next_action.frame_send = 1'b1;
					next_action.frame_kind = lkp_pkg::FR_CFGR;
				end
				lkp_pkg::CMD_TEST:
				begin
					next_action.frame_send = 1'b1;
					next_action.frame_kind = lkp_pkg::FR_TEST;
				end
				lkp_pkg::CMD_DISC:
				begin
					next_action.frame_send = 1'b1;
					next_action.frame_kind = lkp_pkg::FR_DM;
					next_phase = lkp_pkg::PH_DISCONNECTED;
				end
				lkp_pkg::CMD_RD:
				begin
					next_action.frame_send = 1'b1;
					next_action.frame_kind = lkp_pkg::FR_RD;
				end
				default: next_phase = phase;
			endcase
		end
		else if (notify_post && NOTIFY_CODE == lkp_pkg::NTF_DISC && phase == lkp_pkg::PH_INFO)
			next_phase = lkp_pkg::PH_DISCONNECTED;
	end

	always_ff @(posedge CORE_CLK)
	begin
		if (!RSTN)
			phase <= lkp_pkg::PH_STOPPED;
		else
			phase <= next_phase;
	end

	always_ff @(posedge CORE_CLK)
	begin
		if (!RSTN)
			ACTION <= '0;
		else
			ACTION <= next_action;
	end

	// Line controls follow the phase being entered so they change with PHASE
	always_ff @(posedge CORE_CLK)
	begin
		if (!RSTN)
		begin
			PHASE <= lkp_pkg::PH_STOPPED;
			LINE <= '{tx_all_ones: 1'b1, rx_ignore: 1'b1, default: 1'b0};
		end
		else
		begin
			PHASE <= next_phase;
			LINE.tx_all_ones <= next_phase == lkp_pkg::PH_STOPPED;
			LINE.rx_ignore <= next_phase == lkp_pkg::PH_STOPPED;
			LINE.dma_enable <= next_phase != lkp_pkg::PH_STOPPED;
			LINE.tx_flags <= next_phase == lkp_pkg::PH_DISCONNECTED
				|| next_phase == lkp_pkg::PH_INFO;
			LINE.no_header <= next_phase == lkp_pkg::PH_TRANSPARENT;
			LINE.accept_all <= next_phase == lkp_pkg::PH_TRANSPARENT
				&& accept_all_frames;
			LINE.t1_running <= next_phase == lkp_pkg::PH_TRANSPARENT
				&& (next_action.t1_start || (t1_running && !next_action.t1_stop));
		end
	end

	always_ff @(posedge CORE_CLK)
	begin
		if (!RSTN)
			t1_running <= 1'b0;
		else if (next_phase != lkp_pkg::PH_TRANSPARENT || next_action.t1_stop)
			t1_running <= 1'b0;
		else if (next_action.t1_start)
			t1_running <= 1'b1;
	end

	// Init stays done until bus reset; a later stop does not undo the fetch
	always_ff @(posedge CORE_CLK)
	begin
		if (!RSTN)
			init_done <= 1'b0;
		else if (next_action.init_fetch)
			init_done <= 1'b1;
	end

	// ----------------------------------------------------------------
	// Command fields
	// ----------------------------------------------------------------
	// Writes to the code and parameter are dropped while a command is pending
	always_ff @(posedge CORE_CLK)
	begin
		if (!RSTN)
		begin
			cmd_valid_flag <= lkp_pkg::CMD_STATUS_RESET[lkp_pkg::BIT_CMD_VALID];
			cmd_param_bit <= lkp_pkg::CMD_STATUS_RESET[lkp_pkg::BIT_CMD_PARAM];
			cmd_code <= lkp_pkg::CMD_STATUS_RESET[lkp_pkg::CMD_CODE_HI:lkp_pkg::CMD_CODE_LO];
		end
		else if (cmd_valid_flag)
			cmd_valid_flag <= 1'b0;
		else if (wr_cmd_hi && wr_data[lkp_pkg::BIT_CMD_VALID])
		begin
			cmd_valid_flag <= 1'b1;
			cmd_param_bit <= wr_data[lkp_pkg::BIT_CMD_PARAM];
			cmd_code <= wr_data[lkp_pkg::CMD_CODE_HI:lkp_pkg::CMD_CODE_LO];
		end
	end

	// A new conflict in the clearing cycle keeps the flag set
	always_ff @(posedge CORE_CLK)
	begin
		if (!RSTN)
			cmd_error_flag <= lkp_pkg::CMD_STATUS_RESET[lkp_pkg::BIT_CMD_ERROR];
		else if (cmd_valid_flag && !cmd_ok)
			cmd_error_flag <= 1'b1;
		else if (wr_cmd_hi && wr_data[lkp_pkg::BIT_CMD_ERROR])
			cmd_error_flag <= 1'b0;
	end

	// ----------------------------------------------------------------
	// Notifications
	// ----------------------------------------------------------------
	assign notify_clear = wr_cmd_lo && wr_data[lkp_pkg::BIT_NOTIFY_VALID];
	assign notify_post = NOTIFY_REQ && (!notify_valid_flag || notify_clear);

	always_ff @(posedge CORE_CLK)
	begin
		if (!RSTN)
		begin
			notify_valid_flag <= lkp_pkg::CMD_STATUS_RESET[lkp_pkg::BIT_NOTIFY_VALID];
			notify_code <= lkp_pkg::CMD_STATUS_RESET[lkp_pkg::NOTIFY_CODE_HI:0];
		end
		else if (notify_post)
		begin
			notify_valid_flag <= 1'b1;
			notify_code <= NOTIFY_CODE;
		end
		else if (notify_clear)
			notify_valid_flag <= 1'b0;
	end

	always_ff @(posedge CORE_CLK)
	begin
		if (!RSTN)
			notify_lost_flag <= lkp_pkg::CMD_STATUS_RESET[lkp_pkg::BIT_NOTIFY_LOST];
		else if (NOTIFY_REQ && notify_valid_flag && !notify_clear)
			notify_lost_flag <= 1'b1;
		else if (notify_clear)
			notify_lost_flag <= 1'b0;
	end

	// Indications are remembered until answered or the stopped phase is entered, so responses can be checked
	always_ff @(posedge CORE_CLK)
	begin
		if (!RSTN)
			ind_pending <= '0;
		else if (next_phase == lkp_pkg::PH_STOPPED)
			ind_pending <= '0;
		else
			ind_pending <= (ind_pending & ~(cmd_exec ? ind_of_cmd(cmd_code) : '0))
				| (notify_post ? ind_of_notify(NOTIFY_CODE) : '0);
	end

	// ----------------------------------------------------------------
	// Control and read-back
	// ----------------------------------------------------------------
	always_ff @(posedge CORE_CLK)
	begin
		if (!RSTN)
			accept_all_frames <= lkp_pkg::CTRL_RESET;
		else if (wr_ctrl)
			accept_all_frames <= wr_data[lkp_pkg::BIT_ACCEPT_ALL];
	end

	always_comb
	begin
		rd_err = 1'b0;
		rd_data = 32'h00000000;
		if (rd_addr == lkp_pkg::OFF_CMD_STATUS)
			rd_data[15:0] = {cmd_error_flag, cmd_valid_flag, cmd_param_bit, cmd_code,
				notify_lost_flag, notify_valid_flag, notify_code};
		else if (rd_addr == lkp_pkg::OFF_CTRL)
			rd_data[lkp_pkg::BIT_ACCEPT_ALL] = accept_all_frames;
		else if (rd_addr == lkp_pkg::OFF_STATE)
			rd_data[9:0] = {ind_pending, t1_running, init_done, phase};
		else
			rd_err = 1'b1;
	end

endmodule : lkp_cmd_port
`default_nettype wire

// [test/lkp_link_model.sv]
`timescale 1ns/1ps
`default_nettype none
module lkp_link_model (
	input wire logic clk,
	input wire logic post,
	input wire logic [5:0] code,
	output logic req = 1'b0,
	output logic [5:0] ncode = 6'h00
);
	// Code toggles outside posts, so a stale code is never mistaken for a new one
	always @(posedge clk)
	begin
		req <= post;
		ncode <= post ? code : ~ncode;
	end
endmodule : lkp_link_model
`default_nettype wire

// [test/lkp_chk_assertions.sv]
`timescale 1ns/1ps
`default_nettype none
module lkp_chk (
	input wire logic CORE_CLK,
	input wire logic RSTN,
	input wire lkp_pkg::lkp_phase_e PHASE,
	input wire lkp_pkg::lkp_line_s LINE,
	input wire lkp_pkg::lkp_action_s ACTION
);
	default clocking @(posedge CORE_CLK); endclocking
	default disable iff (!RSTN);
	a_stop_line: assert property (PHASE == lkp_pkg::PH_STOPPED |-> LINE.tx_all_ones
		&& LINE.rx_ignore && !LINE.dma_enable) else $error("stopped line wrong");
	a_ring_disc: assert property (ACTION.ring_reset |-> PHASE == lkp_pkg::PH_DISCONNECTED)
		else $error("ring reset outside disconnected");
	a_init_stop: assert property (ACTION.init_fetch |-> PHASE == lkp_pkg::PH_STOPPED)
		else $error("init fetch outside stopped");
	a_bare_trans: assert property (LINE.no_header == (PHASE == lkp_pkg::PH_TRANSPARENT))
		else $error("header mode wrong");
	a_status_once: assert property (ACTION.status_write |=> !ACTION.status_write)
		else $error("status pulse too long");
	a_test_stop: assert property (ACTION.self_test |-> PHASE == lkp_pkg::PH_STOPPED)
		else $error("self test outside stopped");
	a_accept_info: assert property (ACTION.link_accept |-> PHASE == lkp_pkg::PH_INFO
		&& $past(PHASE) == lkp_pkg::PH_DISCONNECTED) else $error("link accept wrong");
	a_t1_trans: assert property (LINE.t1_running |-> PHASE == lkp_pkg::PH_TRANSPARENT)
		else $error("timer outside transparent");
	a_dm_disc: assert property (ACTION.frame_send && ACTION.frame_kind == lkp_pkg::FR_DM
		|-> PHASE == lkp_pkg::PH_DISCONNECTED) else $error("dm without disconnect");
endmodule : lkp_chk
bind lkp_cmd_port lkp_chk chk (.CORE_CLK(CORE_CLK), .RSTN(RSTN), .PHASE(PHASE), .LINE(LINE),
	.ACTION(ACTION));
`default_nettype wire

// [test/tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0, post = 1'b0;
	logic [3:0] awaddr = 4'h0, araddr = 4'h0, wstrb = 4'h0;
	logic [31:0] wdata = 32'h0, rdata, d;
	logic [5:0] pcode = 6'h00, ncode, pend = 6'h00;
	logic [1:0] bresp, rresp, resp;
	logic awready, wready, bvalid, arready, rvalid, nreq;
	lkp_pkg::lkp_phase_e phase;
	lkp_pkg::lkp_line_s line;
	lkp_pkg::lkp_action_s action;
	int errors = 0, comparisons = 0, seed = 65, ph = 0, ini = 0, t1 = 0, nv = 0, lost = 0, nc = 0;
	int c, ind[6] = '{0, 6, 8, 10, 13, 12};
	always #12.5 clk = ~clk;
	lkp_cmd_port uut (.CORE_CLK(clk), .RSTN(rstn), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
		.S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid),
		.S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(1'b1),
		.S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
		.S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(1'b1),
		.NOTIFY_REQ(nreq), .NOTIFY_CODE(ncode), .PHASE(phase), .LINE(line), .ACTION(action));
	lkp_link_model link (.clk(clk), .post(post), .code(pcode), .req(nreq), .ncode(ncode));
	// ----------------------------------------------------------------
	// Bus cycles and checks
	// ----------------------------------------------------------------
	task chk(input logic [31:0] g, input logic [31:0] e);
		comparisons++;
		if (g !== e)
		begin
			errors++;
			$display("ERROR %0t got %h exp %h", $time, g, e);
		end
	endtask : chk
	task wr(input logic [3:0] a, input logic [31:0] v, input logic [3:0] s);
		awaddr <= a; wdata <= v; wstrb <= s; awvalid <= 1'b1; wvalid <= 1'b1;
		do
		begin
			@(posedge clk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
		end
		while (!bvalid);
		resp = bresp;
	endtask : wr
	task rd(input logic [3:0] a, output logic [31:0] v);
		araddr <= a; arvalid <= 1'b1;
		do
		begin
			@(posedge clk);
			if (arvalid && arready) arvalid <= 1'b0;
		end
		while (!rvalid);
		v = rdata; resp = rresp;
	endtask : rd
	task cmd(input int k, input logic p);
		logic ok;
		logic [13:0] ea;
		ok = 1'b1;
		wr(4'h0, {16'h0, 2'b01, p, 5'(k), 8'h00}, 4'h2);
		// The action pulse launched at the write's answer edge stands until this edge
		@(posedge clk);
		case (k)
			0: begin ph = 0; pend = 6'h00; end
			1: if (ph == 0 || ph == 3) ph = p ? 2 : 1; else ok = 0;
			2: if (ph == 0) ini = 1; else ok = 0;
			3: ph = 3;
			4: ok = ini;
			5: ok = (ph == 0);
			7: if (ph == 1 && pend[1]) begin ph = 2; pend[1] = 0; end else ok = 0;
			8, 9:
			begin
				if (ph == 3) t1 = (k == 8);
				else ok = (ph != 0 && pend[k == 8 ? 0 : 2]);
				// Any accepted use of the code consumes its indication, timer use too
				if (ok) pend[k == 8 ? 0 : 2] = 0;
			end
			10, 15: ok = (ph == 1 || ph == 2);
			11, 12, 13: if ((ph == 1 || ph == 2) && pend[k-8]) pend[k-8] = 0; else ok = 0;
			14: if (ph == 1 || ph == 2) ph = 1; else ok = 0;
			default: ok = 0;
		endcase
		ea = 14'h0000;
		if (ok)
			case (k)
				1: ea[13] = !p;
				2: ea[12] = 1'b1;
				4: ea[11] = 1'b1;
				5: ea[10] = 1'b1;
				7: ea[7:5] = {1'b1, !p, p};
				8, 9: if (ph == 3) ea[k == 8 ? 9 : 8] = 1'b1;
					else ea[6:0] = {k == 9 && !p, k == 9 && p, 1'b1, 3'(lkp_pkg::FR_UA), 1'b1};
				10, 11, 12, 13, 14, 15: ea[4:0] = {1'b1, 3'(k - 8), p};
				default: ea = 14'h0000;
			endcase
		// Frame kind and final bit only mean something while a frame is sent
		chk({action[13:4], action.frame_send ? action[3:0] : 4'h0}, ea);
		if (ph != 3) t1 = 0;
		rd(4'h0, d);
		chk(d[15:14], {~ok, 1'b0});
		rd(4'h8, d);
		chk(d[9:0], {pend, 1'(t1), 1'(ini), 2'(ph)});
		chk({phase, line.no_header, line.accept_all}, {2'(ph), ph == 3, ph == 3});
		if (!ok) wr(4'h0, 32'h8000, 4'h2);
	endtask : cmd
	task note(input int k);
		pcode <= 6'(k); post <= 1'b1;
		@(posedge clk);
		post <= 1'b0;
		repeat (3) @(posedge clk);
		if (nv) lost = 1;
		else
		begin
			nv = 1;
			nc = k;
			foreach (ind[i]) if (ind[i] == k) pend[i] = 1'b1;
			if (k == 14 && ph == 2) ph = 1;
		end
		rd(4'h0, d);
		chk(d[7:0], {1'(lost), 1'(nv), 6'(nc)});
	endtask : note
	task results();
		if (errors == 0 && comparisons > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : results
	initial
	begin
		repeat (50000) @(posedge clk);
		errors++;
		results();
	end
	initial
	begin
		repeat (5) @(posedge clk);
		rstn <= 1'b1;
		@(posedge clk);
		rd(4'h0, d);
		chk(d, 32'h0);
		rd(4'hc, d);
		chk(resp, 2'h2);
		wr(4'hc, 32'h1, 4'hf);
		chk(resp, 2'h2);
		wr(4'h4, 32'h1, 4'hf);
		for (c = 0; c < 18; c++) cmd(c, 1'b0);
		repeat (120)
		begin
			c = $unsigned($random(seed)) % 18;
			cmd(c, (c inside {1, 7, 9, 10, 15}) ? 1'($random(seed)) : 1'b0);
			c = $unsigned($random(seed)) % 7;
			if (ph != 0) note(nv ? 1 : (c < 6 ? ind[c] : 14));
			if ($random(seed) & 1) begin wr(4'h0, 32'h40, 4'h1); nv = 0; lost = 0; end
		end
		// Undefined code sets the error flag, then a mid-run reset must clear status and state and restore the stopped line
		wr(4'h0, 32'h4600, 4'h2);
		rstn <= 1'b0;
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
		@(posedge clk);
		rd(4'h0, d);
		chk(d, 32'h0);
		rd(4'h8, d);
		chk(d, 32'h0);
		chk({phase, line}, 9'h050);
		results();
	end
endmodule : tb_top
`default_nettype wire
